//--- core/auxsmi_core.sv
// Auxiliary management-interrupt gathering, forced media change and write-only mirrors
`timescale 1ns/1ps
// How it works
// - Enable one gates port, serial, floppy, watchdog
// - Enable two gates pointer, keys, infrared
// - Enable two bit 4 routes kbc bit
// - Enable two bit 6 feeds serial frame
// - Enable two resets 0x02, keys set
// - Status one mirrors sources, cleared at source
// - Printer flag one when inactive, else acknowledge
// - Infrared edge sets flag, status read clears
// - Status two shows pointer, keys, kbc bit
// - Forced change resets one, software only sets
// - Step with drive select clears forced change
// - Media flag: select AND forced, OR pin
// - Floppy rate mirror holds last write
// - Serial one FIFO mirror holds last write
// - Serial two FIFO mirror, same layout

// Overview of the register side
// Every register is eight bits wide and sits in the low byte of an aligned word
// Upper bits of every read word are zero
// Unaligned or unmapped addresses answer with an error; unaligned ones still take effect on their word

// Bus timing
// The slave inserts one wait state: ready rises in the second access cycle
// Writes land, and read side effects happen, only at the completing edge
// Landing early would let a master that stalls see a half-done transfer

// Read data timing
// Read data are captured one edge before the completing edge
// They stand for exactly the cycle in which ready is high
// Outside that cycle the read word returns to zero

// Status one
// Each bit is a registered copy of its source level
// Nothing in this block can clear it; the source must drop
// Writes to it are accepted on the bus and discarded

// Parallel port status
// While the port is not activated the bit reads as one
// This means an enabled but idle port holds the group output active
// Software must keep the gate off until the port is activated

// Status two
// Pointer, keys and controller bit follow their sources like status one
// The infrared bit is the only sticky bit and clears on a read
// A read and a new edge in one cycle keep the bit set

// Infrared activity
// The receive line is taken after the pin selection
// Switching the selection can itself look like an edge
// The first cycle after reset is ignored so reset never sets it

// Group management output
// It is active low and registered so it never glitches
// It trails a source by two clocks: one for status, one for output
// The serial frame gate is not a source and is masked out of the sum

// Serial frame request
// It follows the group condition only while its gate bit is set
// The far side decides which frame slot carries it
// It is a level, held as long as the group condition holds

// Controller port bit
// It appears in status two whatever its route gate says
// It reaches the group output only when routed
// Its polarity is taken as given by the controller

// Enable two reset
// Every reset flavour forces the keys gate on
// The soft reset pulse touches this register alone
// Other enables and mirrors survive a soft reset

// Forced media change
// It comes up set after reset so a fresh drive is reported changed
// Software may set it again but never clear it
// A step pulse with drive zero selected clears it; a write of one wins a tie

// Media change flag
// It combines the select line, the forced bit and the change pin
// The polarities are the raw pin levels, not decoded ones
// It is registered, so it trails its inputs by one clock

// Mirrors
// They keep a copy of values written into write-only unit registers
// Reserved bits are masked so they always read as zero
// Bus writes to their addresses are silently dropped

// Block events
// Two sticky bits: infrared activity and the group condition becoming active
// Writing a one clears a bit; a new event in that cycle wins
// The level interrupt is high while any unmasked bit is set

// Pin selection and spare
// These are plain storage here; the pin routing lives elsewhere
// Only documented writable bits of the pin selection are kept
// The spare register is fully writable and has no effect

// Limitations
// Inputs are assumed synchronous to the clock; nothing is synchronised
// Pulses shorter than one clock on a source may be missed
// Only one clock domain exists, so no crossing is needed
module auxsmi_core (
   input wire logic clk, // 50 MHz clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic soft_rst, // Soft reset pulse: re-forces keys gate
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic printer_port_active, // Parallel port activate bit
   input wire logic printer_acknowledge_n, // Printer acknowledge input
   input wire logic serial_two_irq, // Second UART interrupt
   input wire logic serial_one_irq, // First UART interrupt
   input wire logic floppy_irq, // Floppy interrupt
   input wire logic watchdog_irq, // Watchdog interrupt
   input wire logic pointer_irq, // Mouse interrupt
   input wire logic keys_irq, // Keyboard interrupt
   input wire logic kbc_port_bit, // Keyboard controller port bit output
   input wire logic serial_two_rx_pin, // Second UART receive pin
   input wire logic infrared_rx_pin, // Infrared receive pin
   input wire logic ir_rx_select, // Receive mux: 1 picks infrared pin
   input wire logic head_step_n, // Drive step output, low active
   input wire logic drive_select_zero_n, // Drive select zero output, low active
   input wire logic media_changed_in_n, // Disk change input pin
   input wire logic rate_wr, // Floppy data-rate register written
   input wire logic [7:0] rate_wdata, // Value written to data-rate register
   input wire logic s1_fifo_wr, // First UART FIFO control written
   input wire logic s2_fifo_wr, // Second UART FIFO control written
   input wire logic [7:0] fifo_wdata, // Value written to FIFO control
   output logic group_mgmt_irq_n, // Group management interrupt, low active
   output logic mgmt_irq_serial_frame, // Request for the serial IRQ frame
   output logic media_changed_flag, // Disk change bit of digital input register
   output logic irq // Block interrupt, level high
);
   logic [7:0] mgmt_irq_enable_one;
   logic [7:0] mgmt_irq_enable_two;
   logic [7:0] mgmt_irq_status_one;
   logic [7:0] mgmt_irq_status_two;
   logic [7:0] spare_reserved;
   logic [7:0] pin_function_select;
   logic forced_media_change;
   logic [7:0] floppy_rate_mirror;
   logic [7:0] serial_one_fifo_mirror;
   logic [7:0] serial_two_fifo_mirror;
   localparam int EV_W_T = auxsmi_pkg::EV_W;
   logic [EV_W_T-1:0] ev_status;
   logic [EV_W_T-1:0] ev_mask;
   logic done;
   logic infrared_activity_flag;
   logic ir_sel_q;
   logic ir_prev_valid;
   logic prev_group;
   logic [9:0] widx;
   logic [7:0] wbyte;
   logic wr_acc;
   logic rd_acc;
   logic acc;
   logic [7:0] next_rdata;
   logic next_err;
   logic ir_now;
   logic group_active;
   logic [7:0] st1_live;
   logic [7:0] st2_live;

   // Address decode; effects ignore the two low address bits, which only raise the error
   assign widx = paddr[11:2];
   assign wbyte = pwdata[7:0];
   assign acc = psel && penable && !pready;
   // Effects wait for the completing edge, where ready is sampled high
   assign done = psel && penable && pready;
   assign wr_acc = done && pwrite;
   assign rd_acc = done && !pwrite;

   // Live status: levels follow their sources so they clear at source
   always_comb begin
      st1_live = auxsmi_pkg::ZERO8;
      st1_live[auxsmi_pkg::B_PRN] = printer_port_active ? printer_acknowledge_n : 1'b1;
      st1_live[auxsmi_pkg::B_SER2] = serial_two_irq;
      st1_live[auxsmi_pkg::B_SER1] = serial_one_irq;
      st1_live[auxsmi_pkg::B_FLOP] = floppy_irq;
      st1_live[auxsmi_pkg::B_WDOG] = watchdog_irq;
      st2_live = auxsmi_pkg::ZERO8;
      st2_live[auxsmi_pkg::B_PTR] = pointer_irq;
      st2_live[auxsmi_pkg::B_KEYS] = keys_irq;
      st2_live[auxsmi_pkg::B_IRDA] = infrared_activity_flag;
      st2_live[auxsmi_pkg::B_KBCP] = kbc_port_bit;
   end

   // Status registers sampled each cycle so reads see a registered value
   always_ff @(posedge clk) begin
      if (rst) begin
         mgmt_irq_status_one <= auxsmi_pkg::ZERO8;
         mgmt_irq_status_two <= auxsmi_pkg::ZERO8;
      end else begin
         mgmt_irq_status_one <= st1_live;
         mgmt_irq_status_two <= st2_live;
      end
   end

   // Enable one: plain read/write of the gate bits
   always_ff @(posedge clk) begin
      if (rst) begin
         mgmt_irq_enable_one <= auxsmi_pkg::EN1_RST;
      end else if (wr_acc && widx == 10'(auxsmi_pkg::IDX_EN1)) begin
         mgmt_irq_enable_one <= wbyte & auxsmi_pkg::EN1_MASK;
      end
   end

   // Enable two: keys gate forced on by every reset flavour
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         mgmt_irq_enable_two <= auxsmi_pkg::EN2_RST;
      end else if (wr_acc && widx == 10'(auxsmi_pkg::IDX_EN2)) begin
         mgmt_irq_enable_two <= wbyte & auxsmi_pkg::EN2_MASK;
      end
   end

   // Spare and pin selection are storage only here
   always_ff @(posedge clk) begin
      if (rst) begin
         spare_reserved <= auxsmi_pkg::SPARE_RST;
         pin_function_select <= auxsmi_pkg::PINSEL_RST;
      end else if (wr_acc && widx == 10'(auxsmi_pkg::IDX_SPARE)) begin
         spare_reserved <= wbyte;
      end else if (wr_acc && widx == 10'(auxsmi_pkg::IDX_PINSEL)) begin
         pin_function_select <= wbyte & auxsmi_pkg::PINSEL_MASK;
      end
   end

   // Infrared activity: any edge on the muxed receive line sets, status-two read clears
   assign ir_now = ir_rx_select ? infrared_rx_pin : serial_two_rx_pin;
   always_ff @(posedge clk) begin
      if (rst) begin
         ir_sel_q <= 1'b0;
         ir_prev_valid <= 1'b0;
         infrared_activity_flag <= 1'b0;
      end else begin
         ir_sel_q <= ir_now;
         ir_prev_valid <= 1'b1;
         // Set wins over the read clear so an edge in the read cycle is kept
         if (ir_prev_valid && (ir_now != ir_sel_q)) begin
            infrared_activity_flag <= 1'b1;
         end else if (rd_acc && widx == 10'(auxsmi_pkg::IDX_ST2)) begin
            infrared_activity_flag <= 1'b0;
         end
      end
   end

   // Forced media change: software can set only, step with select zero clears
   always_ff @(posedge clk) begin
      if (rst) begin
         forced_media_change <= 1'b1;
      end else if (wr_acc && widx == 10'(auxsmi_pkg::IDX_FMC) && wbyte[auxsmi_pkg::B_FMC]) begin
         forced_media_change <= 1'b1;
      end else if (!head_step_n && !drive_select_zero_n) begin
         forced_media_change <= 1'b0;
      end
   end

   // Disk-change flag seen by the floppy digital input register
   always_ff @(posedge clk) begin
      if (rst) begin
         media_changed_flag <= 1'b0;
      end else begin
         media_changed_flag <= (drive_select_zero_n & forced_media_change) | media_changed_in_n;
      end
   end

   // Mirrors follow the unit writes only; bus writes to them are dropped
   always_ff @(posedge clk) begin
      if (rst) begin
         floppy_rate_mirror <= auxsmi_pkg::MIRROR_RST;
         serial_one_fifo_mirror <= auxsmi_pkg::MIRROR_RST;
         serial_two_fifo_mirror <= auxsmi_pkg::MIRROR_RST;
      end else begin
         if (rate_wr) begin
            floppy_rate_mirror <= rate_wdata & auxsmi_pkg::FRATE_MASK;
         end
         if (s1_fifo_wr) begin
            serial_one_fifo_mirror <= fifo_wdata & auxsmi_pkg::FIFO_MASK;
         end
         if (s2_fifo_wr) begin
            serial_two_fifo_mirror <= fifo_wdata & auxsmi_pkg::FIFO_MASK;
         end
      end
   end

   // Group management interrupt: any enabled status, kbc bit only when routed
   always_comb begin
      group_active = |(mgmt_irq_status_one & mgmt_irq_enable_one);
      group_active = group_active |
         |(mgmt_irq_status_two & mgmt_irq_enable_two &
           ~(8'h01 << auxsmi_pkg::B_SFRAME));
   end

   // Outputs registered; serial frame only when its gate is set
   always_ff @(posedge clk) begin
      if (rst) begin
         group_mgmt_irq_n <= 1'b1;
         mgmt_irq_serial_frame <= 1'b0;
      end else begin
         group_mgmt_irq_n <= !group_active;
         mgmt_irq_serial_frame <= group_active && mgmt_irq_enable_two[auxsmi_pkg::B_SFRAME];
      end
   end

   // Block events: infrared activity and group assertion edge; write one clears, set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         ev_status <= EV_W_T'(auxsmi_pkg::EV_RST);
         ev_mask <= EV_W_T'(auxsmi_pkg::EV_RST);
         prev_group <= 1'b0;
         irq <= 1'b0;
      end else begin
         prev_group <= group_active;
         for (int i = 0; i < EV_W_T; i++) begin
            if ((i == auxsmi_pkg::EV_IR && infrared_activity_flag) ||
                (i == auxsmi_pkg::EV_GROUP && group_active && !prev_group)) begin
               ev_status[i] <= 1'b1;
            end else if (wr_acc && widx == 10'(auxsmi_pkg::IDX_EVSTAT) && wbyte[i]) begin
               ev_status[i] <= 1'b0;
            end
         end
         if (wr_acc && widx == 10'(auxsmi_pkg::IDX_EVMASK)) begin
            ev_mask <= wbyte[EV_W_T-1:0];
         end
         irq <= |(ev_status & ev_mask);
      end
   end

   // Read mux and unmapped-address error
   always_comb begin
      next_rdata = auxsmi_pkg::ZERO8;
      next_err = 1'b0;
      if (paddr[1:0] != auxsmi_pkg::BYTE_LSB || widx[9:8] != 2'h0) begin
         next_err = 1'b1;
      end else begin
         unique case (widx[7:0])
            auxsmi_pkg::IDX_EN1: next_rdata = mgmt_irq_enable_one;
            auxsmi_pkg::IDX_EN2: next_rdata = mgmt_irq_enable_two;
            auxsmi_pkg::IDX_ST1: next_rdata = mgmt_irq_status_one;
            auxsmi_pkg::IDX_ST2: next_rdata = mgmt_irq_status_two;
            auxsmi_pkg::IDX_SPARE: next_rdata = spare_reserved;
            auxsmi_pkg::IDX_PINSEL: next_rdata = pin_function_select;
            auxsmi_pkg::IDX_FMC: next_rdata = {7'h00, forced_media_change};
            auxsmi_pkg::IDX_FRATE: next_rdata = floppy_rate_mirror;
            auxsmi_pkg::IDX_S1FIFO: next_rdata = serial_one_fifo_mirror;
            auxsmi_pkg::IDX_S2FIFO: next_rdata = serial_two_fifo_mirror;
            auxsmi_pkg::IDX_EVSTAT: next_rdata = {6'h00, ev_status};
            auxsmi_pkg::IDX_EVMASK: next_rdata = {6'h00, ev_mask};
            default: next_err = 1'b1;
         endcase
      end
   end

   // APB answer: one wait state, ready pulses in the second access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc;
         pslverr <= acc && next_err;
         prdata <= (acc && !pwrite && !next_err) ? {24'h000000, next_rdata} : 32'h0000_0000;
      end
   end
endmodule

//--- include/auxsmi_pkg.sv
// Package for the auxiliary management-interrupt and mirror register block
package auxsmi_pkg;
   // Register word indices (printed offsets are the indices; byte address = 4 * index)
   localparam logic [7:0] IDX_EN1 = 8'hB4;
   localparam logic [7:0] IDX_EN2 = 8'hB5;
   localparam logic [7:0] IDX_ST1 = 8'hB6;
   localparam logic [7:0] IDX_ST2 = 8'hB7;
   localparam logic [7:0] IDX_SPARE = 8'hB8;
   localparam logic [7:0] IDX_PINSEL = 8'hC0;
   localparam logic [7:0] IDX_FMC = 8'hC1;
   localparam logic [7:0] IDX_FRATE = 8'hC2;
   localparam logic [7:0] IDX_S1FIFO = 8'hC3;
   localparam logic [7:0] IDX_S2FIFO = 8'hC4;
   // Block-local interrupt status/mask (chosen offsets)
   localparam logic [7:0] IDX_EVSTAT = 8'hD0;
   localparam logic [7:0] IDX_EVMASK = 8'hD1;
   localparam logic [1:0] BYTE_LSB = 2'h0;
   // Reset values
   localparam logic [7:0] EN1_RST = 8'h00;
   localparam logic [7:0] EN2_RST = 8'h02;
   localparam logic [7:0] PINSEL_RST = 8'h02;
   localparam logic [7:0] SPARE_RST = 8'h00;
   localparam logic [7:0] MIRROR_RST = 8'h00;
   localparam logic [7:0] EV_RST = 8'h00;
   localparam logic [7:0] ZERO8 = 8'h00;
   // Writable bit masks
   localparam logic [7:0] EN1_MASK = 8'h9E;
   localparam logic [7:0] EN2_MASK = 8'h57;
   localparam logic [7:0] FRATE_MASK = 8'hDF;
   localparam logic [7:0] FIFO_MASK = 8'hCF;
   localparam logic [7:0] PINSEL_MASK = 8'h0A;
   // Field positions (common to enable and status)
   localparam int B_PRN = 1;
   localparam int B_SER2 = 2;
   localparam int B_SER1 = 3;
   localparam int B_FLOP = 4;
   localparam int B_WDOG = 7;
   localparam int B_PTR = 0;
   localparam int B_KEYS = 1;
   localparam int B_IRDA = 2;
   localparam int B_KBCP = 4;
   localparam int B_SFRAME = 6;
   localparam int B_FMC = 0;
   // Local event bits
   localparam int EV_IR = 0;
   localparam int EV_GROUP = 1;
   localparam int EV_W = 2;
endpackage

//--- tb/auxsmi_host_model.sv
// Host chipset model that logs group management interrupts and serial frames
`timescale 1ns/1ps
module auxsmi_host_model (
   input wire logic clk, // System clock
   input wire logic rst, // Reset, active high
   input wire logic group_mgmt_irq_n, // Group interrupt, low active
   input wire logic mgmt_irq_serial_frame, // Serial IRQ frame request
   output int smi_count, // Assertions latched by the host
   output int frame_count // Cycles with a frame requested
);
   logic last_n;
   // The host latches on the falling level, as an edge-sensitive input would
   always_ff @(posedge clk) begin
      last_n <= rst ? 1'h1 : group_mgmt_irq_n;
      smi_count <= rst ? 0 : smi_count + int'(last_n && !group_mgmt_irq_n);
      frame_count <= rst ? 0 : frame_count + int'(mgmt_irq_serial_frame);
   end
endmodule

//--- tb/auxsmi_assertions.sv
// Port-level checker for the management-interrupt block
`timescale 1ns/1ps
module auxsmi_chk (
   input wire logic clk, // Clock
   input wire logic rst, // Reset, active high
   input wire logic soft_rst, // Soft reset pulse
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic pready, // APB ready
   input wire logic printer_port_active, // Port activate bit
   input wire logic watchdog_irq, // Watchdog source
   input wire logic keys_irq, // Keyboard source
   input wire logic kbc_port_bit, // Controller port bit
   input wire logic media_changed_in_n, // Change pin
   input wire logic group_mgmt_irq_n, // Group output
   input wire logic mgmt_irq_serial_frame, // Frame request
   input wire logic media_changed_flag // Media flag
);
   logic [7:0] en1;
   logic [7:0] en2;
   wire take = psel && penable && pready && pwrite;
   // Enables are copied from the bus since the checker sees no internals
   always_ff @(posedge clk) begin
      if (rst)
         en1 <= 8'h00;
      else if (take && paddr == 12'h2D0)
         en1 <= pwdata[7:0] & 8'h9E;
   end
   // Soft reset re-forces the keyboard gate only in this register
   always_ff @(posedge clk) begin
      if (rst || soft_rst)
         en2 <= 8'h02;
      else if (take && paddr == 12'h2D4)
         en2 <= pwdata[7:0] & 8'h57;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_WDOG_GATE: assert property ((watchdog_irq && en1[7]) [*3] |-> !group_mgmt_irq_n)
      else $error("enabled watchdog left group output idle");
   AST_KEYS_GATE: assert property ((keys_irq && en2[1]) [*3] |-> !group_mgmt_irq_n)
      else $error("enabled keyboard left group output idle");
   AST_KBC_ROUTE: assert property ((kbc_port_bit && en2[4]) [*3] |-> !group_mgmt_irq_n)
      else $error("routed controller bit left group output idle");
   AST_FRAME_ON: assert property ((keys_irq && en2[1] && en2[6]) [*3] |-> mgmt_irq_serial_frame)
      else $error("serial frame missing");
   AST_FRAME_OFF: assert property (!en2[6] [*3] |-> !mgmt_irq_serial_frame)
      else $error("serial frame without its gate");
   AST_PRN_IDLE: assert property ((!printer_port_active && en1[1]) [*3] |-> !group_mgmt_irq_n)
      else $error("inactive port did not raise group output");
   AST_MEDIA_PIN: assert property (media_changed_in_n [*3] |-> media_changed_flag)
      else $error("media flag low with change pin high");
   AST_ALL_GATED: assert property ((en1 == 8'h00 && (en2 & 8'h17) == 8'h00) [*3] |-> group_mgmt_irq_n)
      else $error("group output active with all gates off");
   AST_READY_PULSE: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("ready not a single pulse after access");
endmodule
bind auxsmi_core auxsmi_chk auxsmi_chk_inst (.*);

//--- tb/testbench.sv
// Self-checking bench for the management-interrupt block
`timescale 1ns/1ps
module testbench;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic soft_rst = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, group_n, frame, mflag, irq;
   logic [15:0] s = 16'h3001;
   logic [7:0] wd = 8'h00;
   logic rate_wr = 1'h0, s1wr = 1'h0, s2wr = 1'h0;
   int bad_count = 0, total_checks = 0, smi_count, frame_count;
   auxsmi_core auxsmi_core_inst (.clk(clk), .rst(rst), .soft_rst(soft_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .printer_port_active(s[0]), .printer_acknowledge_n(s[1]), .serial_two_irq(s[2]), .serial_one_irq(s[3]),
      .floppy_irq(s[4]), .watchdog_irq(s[5]), .pointer_irq(s[6]), .keys_irq(s[7]), .kbc_port_bit(s[8]),
      .serial_two_rx_pin(s[9]), .infrared_rx_pin(s[10]), .ir_rx_select(s[11]), .head_step_n(s[12]),
      .drive_select_zero_n(s[13]), .media_changed_in_n(s[14]), .rate_wr(rate_wr), .rate_wdata(wd),
      .s1_fifo_wr(s1wr), .s2_fifo_wr(s2wr), .fifo_wdata(wd), .group_mgmt_irq_n(group_n),
      .mgmt_irq_serial_frame(frame), .media_changed_flag(mflag), .irq(irq));
   auxsmi_host_model auxsmi_host_model_inst (.clk(clk), .rst(rst), .group_mgmt_irq_n(group_n),
      .mgmt_irq_serial_frame(frame), .smi_count(smi_count), .frame_count(frame_count));
   // Free-running 50 MHz clock
   always #10 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; ready and data are taken at the rising edge, the watchdog ends a hang
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      apb(1'h1, idx, d, r);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] r;
      apb(1'h0, idx, 8'h00, r);
      chk(r, {24'h0, exp});
   endtask
   // Outputs trail sources by two cycles, so three edges is enough
   task automatic settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic setsrc(input logic [15:0] v);
      @(posedge clk);
      s <= v;
      settle;
   endtask
   task automatic t_reset;
      rdc(8'hB4, 8'h00);
      rdc(8'hB5, 8'h02);
      rdc(8'hB6, 8'h00);
      rdc(8'hC1, 8'h01);
      rdc(8'hC0, 8'h02);
      rdc(8'hE0, 8'h00);
      chk(err, 1'h1);
      $display("test reset done");
   endtask
   task automatic t_status_one;
      logic [15:0] v [5] = '{16'h3000, 16'h3005, 16'h3009, 16'h3011, 16'h3021};
      logic [7:0] b [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
      for (int i = 0; i < 5; i++) begin
         setsrc(v[i]);
         rdc(8'hB6, b[i]);
         wr(8'hB6, 8'h00);
         rdc(8'hB6, b[i]);
         chk(group_n, 1'h1);
         wr(8'hB4, ~b[i]);
         settle;
         chk(group_n, 1'h1);
         wr(8'hB4, b[i]);
         settle;
         chk(group_n, 1'h0);
         wr(8'hB4, 8'h00);
      end
      setsrc(16'h3003);
      rdc(8'hB6, 8'h02);
      setsrc(16'h3001);
      rdc(8'hB6, 8'h00);
      chk(smi_count >= 5, 1'h1);
      $display("test status one done");
   endtask
   task automatic t_status_two;
      logic [15:0] v [3] = '{16'h3041, 16'h3081, 16'h3101};
      logic [7:0] b [3] = '{8'h01, 8'h02, 8'h10};
      wr(8'hB5, 8'hFF);
      rdc(8'hB5, 8'h57);
      @(posedge clk) soft_rst <= 1'h1;
      @(posedge clk) soft_rst <= 1'h0;
      rdc(8'hB5, 8'h02);
      wr(8'hB5, 8'h00);
      for (int i = 0; i < 3; i++) begin
         setsrc(v[i]);
         rdc(8'hB7, b[i]);
         chk(group_n, 1'h1);
         wr(8'hB5, 8'h40 | b[i]);
         settle;
         chk({group_n, frame}, 2'h1);
         wr(8'hB5, b[i]);
         settle;
         chk({group_n, frame}, 2'h0);
         wr(8'hB5, 8'h00);
      end
      setsrc(16'h3001);
      $display("test status two done");
   endtask
   task automatic t_infrared;
      wr(8'hD0, 8'hFF);
      setsrc(16'h3A01);
      rdc(8'hB7, 8'h00);
      chk(irq, 1'h0);
      setsrc(16'h3E01);
      chk(irq, 1'h0);
      rdc(8'hB7, 8'h04);
      rdc(8'hB7, 8'h00);
      rdc(8'hD0, 8'h01);
      wr(8'hD1, 8'h01);
      settle;
      chk(irq, 1'h1);
      wr(8'hD0, 8'h01);
      settle;
      chk(irq, 1'h0);
      wr(8'hD1, 8'h00);
      $display("test infrared done");
   endtask
   task automatic t_media;
      chk(mflag, 1'h1);
      wr(8'hC1, 8'h00);
      rdc(8'hC1, 8'h01);
      setsrc(16'h0E01);
      rdc(8'hC1, 8'h00);
      chk(mflag, 1'h0);
      setsrc(16'h3E01);
      chk(mflag, 1'h0);
      setsrc(16'h7E01);
      chk(mflag, 1'h1);
      setsrc(16'h3E01);
      wr(8'hC1, 8'h01);
      rdc(8'hC1, 8'h01);
      settle;
      chk(mflag, 1'h1);
      $display("test media done");
   endtask
   task automatic t_mirrors;
      @(posedge clk) {wd, rate_wr} <= {8'hFF, 1'h1};
      @(posedge clk) {rate_wr, s1wr} <= 2'h1;
      @(posedge clk) {s1wr, s2wr, wd} <= {2'h1, 8'h41};
      @(posedge clk) s2wr <= 1'h0;
      wr(8'hC2, 8'h00);
      wr(8'hC4, 8'hFF);
      rdc(8'hC2, 8'hDF);
      rdc(8'hC3, 8'hCF);
      rdc(8'hC4, 8'h41);
      $display("test mirrors done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Main sequence after five reset cycles
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      t_reset;
      t_status_one;
      t_status_two;
      t_infrared;
      t_media;
      t_mirrors;
      finish_test;
   end
   // The tests need a few hundred cycles; far beyond that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      finish_test;
   end
endmodule
